// >>> logic/ttl_pkg.sv
/*
 Package for the temperature trip limits and status block: register
 selectors, field positions, widths and reset values.
 Assumes one 125 MHz clock and a synchronous active-high reset.
*/
package ttl_pkg;
	localparam int TTL_REG_SEL_W = 2;
	localparam logic [1:0] TTL_SEL_ALARM_HIGH = 2'h0;
	localparam logic [1:0] TTL_SEL_ALARM_LOW = 2'h1;
	localparam logic [1:0] TTL_SEL_CRITICAL = 2'h2;
	localparam logic [1:0] TTL_SEL_READING = 2'h3;
	localparam int TTL_WORD_W = 16;
	localparam int TTL_TEMP_W = 13;
	localparam int TTL_SIGN_POS = 12;
	localparam int TTL_LIM_LSB = 2;
	localparam int TTL_BELOW_POS = 13;
	localparam int TTL_ABOVE_POS = 14;
	localparam int TTL_CRIT_POS = 15;
	localparam logic [15:0] TTL_LIMIT_MASK = 16'h1ffc;
	localparam logic [15:0] TTL_LIMIT_RESET = 16'h0000;
	localparam logic [12:0] TTL_TEMP_RESET = 13'h0000;
endpackage

// >>> logic/ttl_limit_reg.sv
/*
 One writable limit register with unimplemented and zero-reading bits masked.
 Assumes write strobe and lock come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ttl_limit_reg (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic locked,
	input wire logic [ttl_pkg::TTL_WORD_W-1:0] wr_data,
	output logic [ttl_pkg::TTL_WORD_W-1:0] value_q
);
	import ttl_pkg::*;
	logic [TTL_WORD_W-1:0] value_d;
	always_comb begin
		value_d = value_q;
		// RULE4 masked low bits
		if (wr_en && !locked) begin
			value_d = wr_data & TTL_LIMIT_MASK;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			value_q <= TTL_LIMIT_RESET;
		end else begin
			value_q <= value_d;
		end
	end
	// RULE4 spare bits stay clear
	limit_mask_a: assert property (@(posedge clk) disable iff (reset) // RULE4
		(value_q & ~TTL_LIMIT_MASK) == 16'h0000)
		else $error("limit unimplemented bits set");
endmodule
`default_nettype wire

// >>> logic/ttl_trip_status.sv
/*
 Temperature trip limits and status: three limit registers, lock handling,
 trip comparisons and the read-only measurement word with byte read order.
 Assumes the serial protocol engine supplies one-cycle read and write
 strobes and a byte-read strobe, and the converter gives a done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - Writable signed quarter-degree upper alarm limit
// RULE2 - Writable lower alarm limit, same layout
// RULE3 - Writable signed critical limit register
// RULE4 - Two low limit bits ignored, read zero
// RULE5 - Comparisons use currently programmed limits
// RULE6 - Host disables events while changing limits
// RULE7 - Measurement register is read only
// RULE8 - Reading is 13-bit twos complement sixteenths
// RULE9 - Measurement read upper byte then lower
// RULE10 - Trip flags ignore event configuration bits
// RULE11 - Bit 13 set when below lower
// RULE12 - Bit 14 set when above upper
// RULE13 - Bit 15 set at or above critical
// RULE14 - Limits compare at quarter-degree granularity
// RULE15 - Alarm lock blocks alarm limit writes
// RULE16 - Critical lock blocks critical limit writes
// RULE17 - Reading and flags update together
module ttl_trip_status (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_stb,
	input wire logic [ttl_pkg::TTL_REG_SEL_W-1:0] wr_sel,
	input wire logic [ttl_pkg::TTL_WORD_W-1:0] wr_data,
	input wire logic rd_stb,
	input wire logic [ttl_pkg::TTL_REG_SEL_W-1:0] rd_sel,
	input wire logic byte_stb,
	input wire logic alarm_lock,
	input wire logic crit_lock,
	input wire logic conv_done,
	input wire logic [ttl_pkg::TTL_TEMP_W-1:0] conv_temp,
	output logic [ttl_pkg::TTL_WORD_W-1:0] rd_data_q,
	output logic [7:0] rd_byte_q,
	output logic below_alarm_q,
	output logic above_alarm_q,
	output logic above_crit_q
);
	import ttl_pkg::*;
	// Flags are packed by position, so the layout must tile the word exactly
	if (TTL_WORD_W != TTL_TEMP_W + 3 || TTL_SIGN_POS != TTL_TEMP_W - 1) begin : g_word_bad
		$error("reading and flags do not fill the word");
	end
	if (TTL_BELOW_POS != TTL_TEMP_W || TTL_ABOVE_POS != TTL_BELOW_POS + 1) begin : g_flag_bad
		$error("trip flags out of place");
	end

	logic [TTL_WORD_W-1:0] high_lim;
	logic [TTL_WORD_W-1:0] low_lim;
	logic [TTL_WORD_W-1:0] crit_lim;
	logic wr_high;
	logic wr_low;
	logic wr_crit;

	// Writes to the reading selector decode to nothing at all
	assign wr_high = wr_stb && (wr_sel == TTL_SEL_ALARM_HIGH);
	assign wr_low = wr_stb && (wr_sel == TTL_SEL_ALARM_LOW);
	assign wr_crit = wr_stb && (wr_sel == TTL_SEL_CRITICAL);

	// RULE1 upper limit store
	// RULE15 alarm lock gate
	ttl_limit_reg u_high (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_high),
		.locked(alarm_lock),
		.wr_data(wr_data),
		.value_q(high_lim)
	);
	// RULE2 lower limit store
	ttl_limit_reg u_low (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_low),
		.locked(alarm_lock),
		.wr_data(wr_data),
		.value_q(low_lim)
	);
	// RULE3 critical limit store
	// RULE16 critical lock gate
	ttl_limit_reg u_crit (
		.clk(clk),
		.reset(reset),
		.wr_en(wr_crit),
		.locked(crit_lock),
		.wr_data(wr_data),
		.value_q(crit_lim)
	);

	// Limit bits 12:0 used in place as sixteenths, low two bits zero, so the finer reading compares exactly
	logic signed [TTL_TEMP_W-1:0] high_s;
	logic signed [TTL_TEMP_W-1:0] low_s;
	logic signed [TTL_TEMP_W-1:0] crit_s;
	logic signed [TTL_TEMP_W-1:0] temp_s;
	// RULE14 quarter-degree limit scale
	assign high_s = signed'(high_lim[TTL_SIGN_POS:0]);
	assign low_s = signed'(low_lim[TTL_SIGN_POS:0]);
	assign crit_s = signed'(crit_lim[TTL_SIGN_POS:0]);
	assign temp_s = signed'(conv_temp);

	logic [TTL_TEMP_W-1:0] temp_q, temp_d;
	logic below_d, above_d, crit_d;
	always_comb begin
		temp_d = temp_q;
		below_d = below_alarm_q;
		above_d = above_alarm_q;
		crit_d = above_crit_q;
		// RULE17 atomic result update
		// RULE5 live limit comparison
		// RULE10 config-independent flags
		if (conv_done) begin
			// RULE8 signed sixteenth reading
			temp_d = conv_temp;
			// RULE11 below lower flag
			below_d = temp_s < low_s;
			// RULE12 above upper flag
			above_d = temp_s > high_s;
			// RULE13 critical at-or-above flag
			crit_d = temp_s >= crit_s;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			temp_q <= TTL_TEMP_RESET;
			below_alarm_q <= 1'b0;
			above_alarm_q <= 1'b0;
			above_crit_q <= 1'b0;
		end else begin
			temp_q <= temp_d;
			below_alarm_q <= below_d;
			above_alarm_q <= above_d;
			above_crit_q <= crit_d;
		end
	end

	// RULE7 read-only measurement word
	logic [TTL_WORD_W-1:0] meas_word;
	assign meas_word = {above_crit_q, above_alarm_q, below_alarm_q, temp_q};

	// Read latches the word so both bytes come from one snapshot
	logic [TTL_WORD_W-1:0] rd_d;
	logic [7:0] byte_d;
	logic lo_next_q, lo_next_d;
	always_comb begin
		rd_d = rd_data_q;
		byte_d = rd_byte_q;
		lo_next_d = lo_next_q;
		if (rd_stb) begin
			unique case (rd_sel)
				TTL_SEL_ALARM_HIGH: rd_d = high_lim;
				TTL_SEL_ALARM_LOW: rd_d = low_lim;
				TTL_SEL_CRITICAL: rd_d = crit_lim;
				TTL_SEL_READING: rd_d = meas_word;
			endcase
			lo_next_d = 1'b0;
		end else if (byte_stb) begin
			// RULE9 upper byte first
			byte_d = lo_next_q ? rd_data_q[7:0] : rd_data_q[15:8];
			lo_next_d = ~lo_next_q;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data_q <= 16'h0000;
			rd_byte_q <= 8'h00;
			lo_next_q <= 1'b0;
		end else begin
			rd_data_q <= rd_d;
			rd_byte_q <= byte_d;
			lo_next_q <= lo_next_d;
		end
	end

	sequence conv_s;
		conv_done;
	endsequence
	sequence read_word_s;
		(rd_stb && rd_sel == TTL_SEL_READING && !byte_stb) ##1 byte_stb;
	endsequence
	sequence read_byte_s;
		rd_stb ##1 (byte_stb && !rd_stb);
	endsequence
	sequence two_bytes_s;
		read_byte_s ##1 (byte_stb && !rd_stb);
	endsequence
	// RULE13 critical flag value
	crit_flag_a: assert property (@(posedge clk) disable iff (reset) // RULE13
		conv_s |=> above_crit_q == ($past(temp_s) >= $past(crit_s)))
		else $error("critical flag wrong");
	// RULE11 below flag value
	below_flag_a: assert property (@(posedge clk) disable iff (reset) // RULE11
		conv_s |=> below_alarm_q == ($past(temp_s) < $past(low_s)))
		else $error("below flag wrong");
	// RULE12 above flag value
	above_flag_a: assert property (@(posedge clk) disable iff (reset) // RULE12
		conv_s |=> above_alarm_q == ($past(temp_s) > $past(high_s)))
		else $error("above flag wrong");
	// RULE17 results held between conversions
	hold_result_a: assert property (@(posedge clk) disable iff (reset) // RULE17
		!conv_done |=> $stable(meas_word))
		else $error("reading changed without conversion");
	// RULE15 alarm lock holds limits
	alarm_lock_a: assert property (@(posedge clk) disable iff (reset) // RULE15
		alarm_lock |=> $stable(high_lim) && $stable(low_lim))
		else $error("alarm limit written while locked");
	// RULE16 critical lock holds limit
	crit_lock_a: assert property (@(posedge clk) disable iff (reset) // RULE16
		crit_lock |=> $stable(crit_lim))
		else $error("critical limit written while locked");
	// RULE1 upper limit write lands
	high_write_a: assert property (@(posedge clk) disable iff (reset) // RULE1
		wr_high && !alarm_lock |=> high_lim == ($past(wr_data) & TTL_LIMIT_MASK))
		else $error("upper limit write lost");
	// RULE2 lower limit write lands
	low_write_a: assert property (@(posedge clk) disable iff (reset) // RULE2
		wr_low && !alarm_lock |=> low_lim == ($past(wr_data) & TTL_LIMIT_MASK))
		else $error("lower limit write lost");
	// RULE3 critical limit write lands
	crit_write_a: assert property (@(posedge clk) disable iff (reset) // RULE3
		wr_crit && !crit_lock |=> crit_lim == ($past(wr_data) & TTL_LIMIT_MASK))
		else $error("critical limit write lost");
	// RULE1 upper write touches nothing else
	high_only_a: assert property (@(posedge clk) disable iff (reset) // RULE1
		wr_high |=> $stable(low_lim) && $stable(crit_lim))
		else $error("upper write disturbed another limit");
	// RULE2 lower write touches nothing else
	low_only_a: assert property (@(posedge clk) disable iff (reset) // RULE2
		wr_low |=> $stable(high_lim) && $stable(crit_lim))
		else $error("lower write disturbed another limit");
	// RULE3 critical write touches nothing else
	crit_only_a: assert property (@(posedge clk) disable iff (reset) // RULE3
		wr_crit |=> $stable(high_lim) && $stable(low_lim))
		else $error("critical write disturbed another limit");
	// RULE5 limits move only on writes
	limit_idle_a: assert property (@(posedge clk) disable iff (reset) // RULE5
		!wr_stb |=> $stable({high_lim, low_lim, crit_lim}))
		else $error("limit changed without a write");
	// RULE7 reading selector not writable
	sel_ignored_a: assert property (@(posedge clk) disable iff (reset) // RULE7
		(wr_stb && wr_sel == TTL_SEL_READING) |=> $stable({high_lim, low_lim, crit_lim}))
		else $error("write to the reading changed a limit");
	// RULE8 reading stored as converted
	reading_store_a: assert property (@(posedge clk) disable iff (reset) // RULE8
		conv_s |=> temp_q == $past(conv_temp))
		else $error("reading not stored");
	// RULE11 equal to lower is inside
	below_equal_a: assert property (@(posedge clk) disable iff (reset) // RULE11
		(conv_done && temp_s == low_s) |=> !below_alarm_q)
		else $error("below flag set at the lower limit");
	// RULE12 equal to upper is inside
	above_equal_a: assert property (@(posedge clk) disable iff (reset) // RULE12
		(conv_done && temp_s == high_s) |=> !above_alarm_q)
		else $error("above flag set at the upper limit");
	// RULE13 equal to critical trips
	crit_equal_a: assert property (@(posedge clk) disable iff (reset) // RULE13
		(conv_done && temp_s == crit_s) |=> above_crit_q)
		else $error("critical flag clear at the critical limit");
	// RULE11 ordered window never both
	window_excl_a: assert property (@(posedge clk) disable iff (reset) // RULE11
		(conv_done && low_s <= high_s) |=> !(below_alarm_q && above_alarm_q))
		else $error("below and above flags both set");
	// RULE7 reading latched whole
	meas_read_a: assert property (@(posedge clk) disable iff (reset) // RULE7
		(rd_stb && rd_sel == TTL_SEL_READING) |=> rd_data_q == $past(meas_word))
		else $error("reading word not latched");
	// RULE1 upper limit read back
	high_read_a: assert property (@(posedge clk) disable iff (reset) // RULE1
		(rd_stb && rd_sel == TTL_SEL_ALARM_HIGH) |=> rd_data_q == $past(high_lim))
		else $error("upper limit read wrong");
	// RULE2 lower limit read back
	low_read_a: assert property (@(posedge clk) disable iff (reset) // RULE2
		(rd_stb && rd_sel == TTL_SEL_ALARM_LOW) |=> rd_data_q == $past(low_lim))
		else $error("lower limit read wrong");
	// RULE3 critical limit read back
	crit_read_a: assert property (@(posedge clk) disable iff (reset) // RULE3
		(rd_stb && rd_sel == TTL_SEL_CRITICAL) |=> rd_data_q == $past(crit_lim))
		else $error("critical limit read wrong");
	// RULE4 spare limit bits read zero
	spare_zero_a: assert property (@(posedge clk) disable iff (reset) // RULE4
		(rd_stb && rd_sel != TTL_SEL_READING) |=> (rd_data_q & ~TTL_LIMIT_MASK) == 16'h0000)
		else $error("limit read shows spare bits");
	// RULE17 snapshot held between reads
	word_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE17
		!rd_stb |=> $stable(rd_data_q))
		else $error("read word changed without a read");
	// RULE9 upper byte first on the reading
	byte_order_a: assert property (@(posedge clk) disable iff (reset) // RULE9
		read_word_s |=> rd_byte_q == rd_data_q[15:8])
		else $error("upper byte not first");
	// RULE9 every read restarts high
	first_byte_a: assert property (@(posedge clk) disable iff (reset) // RULE9
		read_byte_s |=> rd_byte_q == rd_data_q[15:8])
		else $error("read did not restart at the upper byte");
	// RULE9 lower byte second
	second_byte_a: assert property (@(posedge clk) disable iff (reset) // RULE9
		two_bytes_s |=> rd_byte_q == rd_data_q[7:0])
		else $error("lower byte not second");
	// RULE9 byte held without a strobe
	byte_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE9
		(!byte_stb || rd_stb) |=> $stable(rd_byte_q))
		else $error("byte changed without a byte strobe");
	// RULE17 reset clears results
	reset_state_a: assert property (@(posedge clk) disable iff (reset) // RULE17
		$past(reset) |-> {meas_word, rd_data_q, rd_byte_q} == {3'h0, TTL_TEMP_RESET, 24'h000000})
		else $error("results not cleared by reset");
endmodule
`default_nettype wire

// >>> testbench/ttl_host_model.sv
/*
 Host model: issues write, read and byte strobes on the falling edge.
 Assumes the device samples all strobes on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ttl_host_model (
	input wire logic clk,
	output logic wr_stb,
	output logic [1:0] wr_sel,
	output logic [15:0] wr_data,
	output logic rd_stb,
	output logic [1:0] rd_sel,
	output logic byte_stb,
	input wire logic [15:0] rd_data_q,
	input wire logic [7:0] rd_byte_q
);
	initial begin
		{wr_stb, rd_stb, byte_stb, wr_sel, rd_sel, wr_data} = '0;
	end
	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		@(negedge clk);
		wr_sel = s;
		wr_data = d;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
		wr_data = ~d;
	endtask
	// Released read select and write data are inverted so stale values never pass
	task automatic rd(input logic [1:0] s, output logic [15:0] w, output logic [15:0] b);
		@(negedge clk);
		rd_sel = s;
		rd_stb = 1'b1;
		@(negedge clk);
		rd_stb = 1'b0;
		rd_sel = ~s;
		w = rd_data_q;
		byte_stb = 1'b1;
		@(negedge clk);
		b[15:8] = rd_byte_q;
		@(negedge clk);
		byte_stb = 1'b0;
		b[7:0] = rd_byte_q;
	endtask
	// One byte only, so the pointer is left on the lower half
	task automatic rd_half(input logic [1:0] s, output logic [7:0] u);
		@(negedge clk);
		rd_sel = s;
		rd_stb = 1'b1;
		@(negedge clk);
		rd_stb = 1'b0;
		rd_sel = ~s;
		byte_stb = 1'b1;
		@(negedge clk);
		byte_stb = 1'b0;
		u = rd_byte_q;
	endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
 Self-checking bench with a reference model of limits, reading and flags.
 Assumes the host model drives the register strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ttl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic alarm_lock = 1'b0, crit_lock = 1'b0, conv_done = 1'b0;
	logic [12:0] conv_temp = '0;
	logic wr_stb, rd_stb, byte_stb, below_alarm_q, above_alarm_q, above_crit_q;
	logic [1:0] wr_sel, rd_sel;
	logic [15:0] wr_data, rd_data_q, w, b, e, mw = 16'h0000;
	logic [7:0] rd_byte_q, u;
	logic [15:0] lim [3] = '{default: 16'h0000};
	logic [31:0] seed = 32'hde5f, r;
	int tmp = 0, error_cnt = 0, comparisons = 0, cyc = 0;
	always #4 clk = ~clk;
	ttl_host_model i_ttl_host_model (.clk(clk), .wr_stb(wr_stb), .wr_sel(wr_sel),
		.wr_data(wr_data), .rd_stb(rd_stb), .rd_sel(rd_sel), .byte_stb(byte_stb),
		.rd_data_q(rd_data_q), .rd_byte_q(rd_byte_q));
	ttl_trip_status i_ttl_trip_status (.clk(clk), .reset(reset), .wr_stb(wr_stb),
		.wr_sel(wr_sel), .wr_data(wr_data), .rd_stb(rd_stb), .rd_sel(rd_sel),
		.byte_stb(byte_stb), .alarm_lock(alarm_lock), .crit_lock(crit_lock),
		.conv_done(conv_done), .conv_temp(conv_temp), .rd_data_q(rd_data_q),
		.rd_byte_q(rd_byte_q), .below_alarm_q(below_alarm_q),
		.above_alarm_q(above_alarm_q), .above_crit_q(above_crit_q));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int sx(input logic [15:0] v);
		return int'($signed(v[12:0]));
	endfunction
	function automatic logic [15:0] meas();
		logic [15:0] t;
		t = 16'(tmp);
		return {tmp >= sx(lim[2]), tmp > sx(lim[0]), tmp < sx(lim[1]), t[12:0]};
	endfunction
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk_all();
		for (int i = 0; i < 4; i++) begin
			e = (i < 3) ? lim[i] : mw;
			i_ttl_host_model.rd(2'(i), w, b);
			check("word", w, e);
			check("bytes", b, e);
		end
		check("flags", {13'h0, above_crit_q, above_alarm_q, below_alarm_q}, {13'h0, e[15:13]});
	endtask
	// Lock gates only the limits it owns; selector 3 is never writable
	task automatic wlim(input logic [1:0] s, input logic [15:0] d);
		i_ttl_host_model.wr(s, d);
		if (s < 2 && !alarm_lock || s == 2 && !crit_lock) begin
			lim[s] = d & TTL_LIMIT_MASK;
		end
	endtask
	task automatic conv(input logic [12:0] t);
		@(negedge clk);
		conv_temp = t;
		conv_done = 1'b1;
		tmp = int'($signed(t));
		mw = meas();
		@(negedge clk);
		conv_done = 1'b0;
		conv_temp = ~t;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		chk_all();
		for (int k = 0; k < 40; k++) begin
			alarm_lock = (k >= 30);
			crit_lock = (k >= 35);
			r = rnd();
			wlim(r[1:0], r[31:16]);
			r = rnd();
			// Even passes hit a limit exactly to probe the equal case
			conv(k[0] ? r[12:0] : lim[k % 3][12:0]);
			chk_all();
		end
		// A lone byte leaves the pointer low; the next read must restart high
		i_ttl_host_model.rd_half(2'h3, u);
		check("upper", {8'h00, u}, {8'h00, mw[15:8]});
		chk_all();
		give_verdict();
	end
endmodule
`default_nettype wire
